/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic wr;
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
  } ofm_row_s;
  localparam logic [31:0] A_KEY = ofm_pkg::ADDR_KEY;
  localparam logic [31:0] A_EN = ofm_pkg::ADDR_EN;
  localparam logic [31:0] A_LD = ofm_pkg::ADDR_LOW_DIRECT;
  localparam logic [31:0] A_LM = ofm_pkg::ADDR_LOW_MULT;
  localparam logic [31:0] A_HD = ofm_pkg::ADDR_HIGH_DIRECT;
  localparam logic [31:0] A_HM = ofm_pkg::ADDR_HIGH_MULT;
  localparam logic [31:0] A_BAD = 32'h4004_0818;
  logic aclk, aresetn, cpu_clk_in, cpu_run, multiplier_active, stop_mode;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, io_hiz_reset, clock_stop_hold;
  logic [1:0] bresp, rresp, rs;
  int n_errors = 0;
  int num_checks = 0;
  ofm_row_s rows [0:20];

  ofm_top #(.WIN(8)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cpu_clk_in(cpu_clk_in),
    .multiplier_active(multiplier_active), .stop_mode(stop_mode),
    .io_hiz_reset(io_hiz_reset), .clock_stop_hold(clock_stop_hold)
  );

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Two sampled aclk cycles per CPU clock period, so four edges a window.
  always @(posedge aclk)
    cpu_clk_in <= cpu_run ? ~cpu_clk_in : 1'b0;

  task test_done;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_up;
    n_errors++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    test_done();
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50 && !(bready && bvalid); i++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    if (i == 50) give_up();
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdr(input logic [31:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50 && !(rready && rvalid); i++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    if (i == 50) give_up();
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wait_hiz(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && io_hiz_reset !== v; i++)
      @(posedge aclk);
    chk({31'h0, io_hiz_reset}, {31'h0, v});
    if (io_hiz_reset !== v) test_done();
  endtask

  task automatic stay_low(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      chk({31'h0, io_hiz_reset}, 32'h0);
    end
  endtask

  initial
  begin
    rows[0] = '{1'b0, A_KEY, 32'h0, 32'h0000_0006};
    rows[1] = '{1'b0, A_EN, 32'h0, 32'h0000_0000};
    rows[2] = '{1'b0, A_LD, 32'h0, 32'h0000_0010};
    rows[3] = '{1'b0, A_LM, 32'h0, 32'h0000_00D1};
    rows[4] = '{1'b0, A_HD, 32'h0, 32'h0000_0028};
    rows[5] = '{1'b0, A_HM, 32'h0, 32'h0000_0139};
    rows[6] = '{1'b1, A_LD, 32'h0000_0003, 32'h0000_0010};
    rows[7] = '{1'b1, A_KEY, 32'h0000_0055, 32'h0000_0006};
    rows[8] = '{1'b1, A_KEY, 32'h0000_00F9, 32'h0000_00F9};
    rows[9] = '{1'b1, A_EN, 32'h0000_0012, 32'h0000_0000};
    rows[10] = '{1'b1, A_LD, 32'hFFFF_FE03, 32'h0000_0003};
    rows[11] = '{1'b1, A_HD, 32'h0000_0005, 32'h0000_0005};
    rows[12] = '{1'b1, A_LM, 32'h0000_0001, 32'h0000_0001};
    rows[13] = '{1'b1, A_HM, 32'h0000_0102, 32'h0000_0102};
    rows[14] = '{1'b1, A_KEY, 32'h0000_0006, 32'h0000_0006};
    rows[15] = '{1'b1, A_EN, 32'h0000_00E4, 32'h0000_0000};
    rows[16] = '{1'b1, A_KEY, 32'h0000_00F9, 32'h0000_00F9};
    rows[17] = '{1'b1, A_EN, 32'h0000_00E4, 32'h0000_00E4};
    rows[18] = '{1'b1, A_LD, 32'h0000_01FF, 32'h0000_0003};
    rows[19] = '{1'b1, A_KEY, 32'h0000_0006, 32'h0000_0006};
    rows[20] = '{1'b1, A_EN, 32'h0000_0000, 32'h0000_00E4};
    {aresetn, awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {cpu_run, multiplier_active, stop_mode} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    cpu_run <= 1'b1;
    @(posedge aclk);
    foreach (rows[i])
    begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].data);
      if (rows[i].wr) chk({30'h0, rs}, 32'h0);
      rdr(rows[i].addr);
      chk(rd, rows[i].exp);
    end
    stay_low(30);
    // The multiplied pair 1..2 rejects four edges; the forced direct pair 3..5 admits them.
    wr(A_KEY, 32'h0000_00F9);
    wr(A_EN, 32'h0000_0000);
    wr(A_HM, 32'h0000_0002);
    multiplier_active <= 1'b1;
    wr(A_EN, 32'h0000_00E4);
    wr(A_KEY, 32'h0000_0006);
    wait_hiz(1'b1, 40);
    wait_hiz(1'b0, 40);
    cpu_run <= 1'b0;
    wait_hiz(1'b1, 40);
    // Let one whole window pass with the clock stopped.
    repeat (10) @(posedge aclk);
    chk({31'h0, clock_stop_hold}, 32'h1);
    rdr(A_EN);
    chk(rd, 32'h0000_00E4);
    cpu_run <= 1'b1;
    wait_hiz(1'b0, 40);
    cpu_run <= 1'b0;
    wait_hiz(1'b1, 40);
    stop_mode <= 1'b1;
    wait_hiz(1'b0, 4);
    stay_low(20);
    stop_mode <= 1'b0;
    wr(A_BAD, 32'h0000_00F9);
    chk({30'h0, rs}, {30'h0, ofm_pkg::RESP_SLVERR});
    rdr(A_BAD);
    chk({30'h0, rs}, {30'h0, ofm_pkg::RESP_SLVERR});
    chk(rd, 32'h0000_0000);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({31'h0, io_hiz_reset}, 32'h0);
    rdr(A_KEY);
    chk(rd, 32'h0000_0006);
    rdr(A_EN);
    chk(rd, 32'h0000_0000);
    rdr(A_LD);
    chk(rd, 32'h0000_0010);
    test_done();
  end
endmodule

/* File: hw/ofm_meas_counter.sv */
`timescale 1ns/1ps
// Counts rising edges of the sampled CPU clock over a fixed window of
// reference cycles, then presents a saturated count and a done pulse.
module ofm_meas_counter #(
  parameter int CNT_W = ofm_pkg::LIMIT_W,
  parameter int WIN = ofm_pkg::MEAS_WINDOW
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic cpu_clk_in,
  output logic [CNT_W-1:0] count,
  output logic done
);
  localparam int WW = $clog2(WIN + 1);
  localparam logic [WW-1:0] WIN_LAST = WW'(WIN - 1);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  logic [WW-1:0] win_ff, nxt_win;
  logic [CNT_W-1:0] edges_ff, nxt_edges;
  logic [CNT_W-1:0] count_ff, nxt_count;
  logic prev_ff, nxt_prev;
  logic done_ff, nxt_done;
  logic rise;

  always_comb
  begin
    nxt_prev = cpu_clk_in;
    rise = cpu_clk_in && !prev_ff;
    nxt_win = win_ff;
    nxt_edges = edges_ff;
    nxt_count = count_ff;
    nxt_done = 1'b0;
    if (!run)
    begin
      nxt_win = '0;
      nxt_edges = '0;
    end
    else if (win_ff == WIN_LAST)
    begin
      nxt_count = (rise && edges_ff != CNT_MAX) ? edges_ff + 1'b1 : edges_ff;
      nxt_done = 1'b1;
      nxt_win = '0;
      nxt_edges = '0;
    end
    else
    begin
      nxt_win = win_ff + 1'b1;
      if (rise && edges_ff != CNT_MAX)
      begin
        nxt_edges = edges_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      win_ff <= '0;
      edges_ff <= '0;
      count_ff <= '0;
      prev_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      win_ff <= nxt_win;
      edges_ff <= nxt_edges;
      count_ff <= nxt_count;
      prev_ff <= nxt_prev;
      done_ff <= nxt_done;
    end
  end

  assign count = count_ff;
  assign done = done_ff;
endmodule

/* File: hw/ofm_pkg.sv */
package ofm_pkg;
  localparam int LIMIT_W = 9;
  localparam logic [31:0] ADDR_KEY = 32'h4004_0800;
  localparam logic [31:0] ADDR_EN = 32'h4004_0804;
  localparam logic [31:0] ADDR_LOW_DIRECT = 32'h4004_0808;
  localparam logic [31:0] ADDR_LOW_MULT = 32'h4004_080C;
  localparam logic [31:0] ADDR_HIGH_DIRECT = 32'h4004_0810;
  localparam logic [31:0] ADDR_HIGH_MULT = 32'h4004_0814;
  localparam logic [7:0] KEY_UNLOCK = 8'hF9;
  localparam logic [7:0] KEY_LOCK = 8'h06;
  localparam logic [7:0] EN_ON = 8'hE4;
  localparam logic [7:0] EN_OFF = 8'h00;
  localparam logic [7:0] KEY_RESET = 8'h06;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [8:0] LOW_DIRECT_RESET = 9'h010;
  localparam logic [8:0] LOW_MULT_RESET = 9'h0D1;
  localparam logic [8:0] HIGH_DIRECT_RESET = 9'h028;
  localparam logic [8:0] HIGH_MULT_RESET = 9'h139;
  // Reference clock cycles in one measurement window.
  localparam int MEAS_WINDOW = 64;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    LIM_LOW_DIRECT,
    LIM_LOW_MULT,
    LIM_HIGH_DIRECT,
    LIM_HIGH_MULT
  } ofm_lim_e;
endpackage

/* File: hw/ofm_top.sv */
`timescale 1ns/1ps
// What this block does
// - Key 0xF9 unlocks enable and limit writes, 0x06 locks them.
// - Any other key value written is stored as the lock code.
// - Enable register starts monitoring on 0xE4, stops on 0x00, if unlocked.
// - Other values written to the enable register are discarded.
// - Enable register always reads back its contents.
// - Limit writes are blocked while monitoring is enabled.
// - Count outside the window asserts the I/O high-impedance reset.
// - Direct limits used with multiplier off, multiplied limits with it on.
// - Own registers survive the monitor reset; reset holds until in window.
// - A stopped clock holds internal state until oscillation restarts.
// - Monitor resets only outside STOP; STOP suspends detection.
// - A monitor reset with multiplier on forces the direct limit pair.
// - Bus reset sets key to 0x06 and enable to zero.
module ofm_top #(
  parameter int WIN = ofm_pkg::MEAS_WINDOW
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_clk_in,
  input wire logic multiplier_active,
  input wire logic stop_mode,
  output logic io_hiz_reset,
  output logic clock_stop_hold
);
  localparam int LW = ofm_pkg::LIMIT_W;

  logic [7:0] key_ff, nxt_key;
  logic [7:0] en_ff, nxt_en;
  logic [LW-1:0] lim_ff [4];
  logic [LW-1:0] nxt_lim [4];
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic rst_ff, nxt_rst;
  logic force_direct_ff, nxt_force_direct;
  logic stopped_ff, nxt_stopped;

  logic wr_fire, rd_fire, unlocked, monitoring, active, use_mult;
  logic wr_key, wr_en, wr_ok_en, wr_lim_any, wr_lim_ok;
  logic [3:0] wr_lim;
  logic [LW-1:0] lo_lim, hi_lim, meas_count;
  logic meas_done, outside;

  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign rd_fire = s_axi_arvalid && !rvalid_ff;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = !rvalid_ff;

  assign unlocked = key_ff == ofm_pkg::KEY_UNLOCK;
  assign monitoring = en_ff == ofm_pkg::EN_ON;
  assign active = monitoring && !stop_mode;
  assign wr_key = wr_fire && s_axi_awaddr == ofm_pkg::ADDR_KEY
    && s_axi_wstrb[0];
  assign wr_en = wr_fire && s_axi_awaddr == ofm_pkg::ADDR_EN
    && s_axi_wstrb[0];
  assign wr_ok_en = wr_en && unlocked
    && (s_axi_wdata[7:0] == ofm_pkg::EN_ON
    || s_axi_wdata[7:0] == ofm_pkg::EN_OFF);
  assign wr_lim_any = |wr_lim;
  assign wr_lim_ok = unlocked && !monitoring;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lim
      assign wr_lim[gi] = wr_fire && s_axi_awaddr
        == ofm_pkg::ADDR_LOW_DIRECT + 32'(4 * gi);
    end
  endgenerate

  always_comb
  begin
    nxt_key = key_ff;
    nxt_en = en_ff;
    nxt_lim = lim_ff;
    if (wr_key)
    begin
      nxt_key = (s_axi_wdata[7:0] == ofm_pkg::KEY_UNLOCK)
        ? ofm_pkg::KEY_UNLOCK : ofm_pkg::KEY_LOCK;
    end
    if (wr_ok_en)
    begin
      nxt_en = s_axi_wdata[7:0];
    end
    for (int i = 0; i < 4; i++)
    begin
      if (wr_lim[i] && wr_lim_ok)
      begin
        if (s_axi_wstrb[0])
        begin
          nxt_lim[i][7:0] = s_axi_wdata[7:0];
        end
        if (s_axi_wstrb[1])
        begin
          nxt_lim[i][LW-1:8] = s_axi_wdata[LW-1:8];
        end
      end
    end
  end

  // Bus answers: protected writes complete with OKAY but store nothing.
  always_comb
  begin
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (bvalid_ff && s_axi_bready)
    begin
      nxt_bvalid = 1'b0;
    end
    if (wr_fire)
    begin
      nxt_bvalid = 1'b1;
      nxt_bresp = (wr_key || wr_en || wr_lim_any
        || s_axi_awaddr == ofm_pkg::ADDR_KEY
        || s_axi_awaddr == ofm_pkg::ADDR_EN)
        ? ofm_pkg::RESP_OKAY : ofm_pkg::RESP_SLVERR;
    end
    if (rvalid_ff && s_axi_rready)
    begin
      nxt_rvalid = 1'b0;
    end
    if (rd_fire)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = ofm_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        ofm_pkg::ADDR_KEY: nxt_rdata = {24'h00_0000, key_ff};
        ofm_pkg::ADDR_EN: nxt_rdata = {24'h00_0000, en_ff};
        ofm_pkg::ADDR_LOW_DIRECT:
          nxt_rdata = {23'h00_0000, lim_ff[ofm_pkg::LIM_LOW_DIRECT]};
        ofm_pkg::ADDR_LOW_MULT:
          nxt_rdata = {23'h00_0000, lim_ff[ofm_pkg::LIM_LOW_MULT]};
        ofm_pkg::ADDR_HIGH_DIRECT:
          nxt_rdata = {23'h00_0000, lim_ff[ofm_pkg::LIM_HIGH_DIRECT]};
        ofm_pkg::ADDR_HIGH_MULT:
          nxt_rdata = {23'h00_0000, lim_ff[ofm_pkg::LIM_HIGH_MULT]};
        default:
        begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = ofm_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  ofm_meas_counter #(
    .CNT_W(LW),
    .WIN(WIN)
  ) u_meas (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(active),
    .cpu_clk_in(cpu_clk_in),
    .count(meas_count),
    .done(meas_done)
  );

  assign use_mult = multiplier_active && !force_direct_ff;
  assign lo_lim = use_mult ? lim_ff[ofm_pkg::LIM_LOW_MULT]
    : lim_ff[ofm_pkg::LIM_LOW_DIRECT];
  assign hi_lim = use_mult ? lim_ff[ofm_pkg::LIM_HIGH_MULT]
    : lim_ff[ofm_pkg::LIM_HIGH_DIRECT];
  assign outside = meas_count < lo_lim || meas_count > hi_lim;

  // The monitor reset is an output only; it never clears these registers.
  always_comb
  begin
    nxt_rst = rst_ff;
    nxt_stopped = stopped_ff;
    nxt_force_direct = force_direct_ff;
    if (!active)
    begin
      nxt_rst = 1'b0;
      nxt_stopped = 1'b0;
    end
    else if (meas_done)
    begin
      nxt_rst = outside;
      nxt_stopped = meas_count == '0;
    end
    if (nxt_rst && !rst_ff && multiplier_active)
    begin
      nxt_force_direct = 1'b1;
    end
    else if (!multiplier_active)
    begin
      nxt_force_direct = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      key_ff <= ofm_pkg::KEY_RESET;
      en_ff <= ofm_pkg::EN_RESET;
      lim_ff[ofm_pkg::LIM_LOW_DIRECT] <= ofm_pkg::LOW_DIRECT_RESET;
      lim_ff[ofm_pkg::LIM_LOW_MULT] <= ofm_pkg::LOW_MULT_RESET;
      lim_ff[ofm_pkg::LIM_HIGH_DIRECT] <= ofm_pkg::HIGH_DIRECT_RESET;
      lim_ff[ofm_pkg::LIM_HIGH_MULT] <= ofm_pkg::HIGH_MULT_RESET;
      bvalid_ff <= 1'b0;
      bresp_ff <= ofm_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= ofm_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      rst_ff <= 1'b0;
      force_direct_ff <= 1'b0;
      stopped_ff <= 1'b0;
    end
    else
    begin
      key_ff <= nxt_key;
      en_ff <= nxt_en;
      lim_ff <= nxt_lim;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      rst_ff <= nxt_rst;
      force_direct_ff <= nxt_force_direct;
      stopped_ff <= nxt_stopped;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign io_hiz_reset = rst_ff;
  assign clock_stop_hold = stopped_ff;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_key_bad_locks: assert property (
    wr_key && s_axi_wdata[7:0] != ofm_pkg::KEY_UNLOCK
    |=> key_ff == ofm_pkg::KEY_LOCK)
    else $error("key not locked after bad write");
  a_key_unlock: assert property (
    wr_key && s_axi_wdata[7:0] == ofm_pkg::KEY_UNLOCK
    |=> unlocked)
    else $error("key not unlocked");
  a_en_locked_hold: assert property (
    wr_en && !unlocked |=> $stable(en_ff))
    else $error("enable written while locked");
  a_en_bad_code: assert property (
    wr_en && s_axi_wdata[7:0] != ofm_pkg::EN_ON
    && s_axi_wdata[7:0] != ofm_pkg::EN_OFF |=> $stable(en_ff))
    else $error("enable took an invalid code");
  a_en_start: assert property (
    wr_en && unlocked && s_axi_wdata[7:0] == ofm_pkg::EN_ON
    |=> monitoring)
    else $error("monitoring did not start");
  a_en_read_back: assert property (
    rd_fire && s_axi_araddr == ofm_pkg::ADDR_EN
    |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(en_ff)})
    else $error("enable readback wrong");
  a_lim_blocked: assert property (
    wr_lim_any && monitoring
    |=> $stable({lim_ff[0], lim_ff[1], lim_ff[2], lim_ff[3]}))
    else $error("limit written while monitoring");
  a_lim_locked: assert property (
    wr_lim_any && !unlocked
    |=> $stable({lim_ff[0], lim_ff[1], lim_ff[2], lim_ff[3]}))
    else $error("limit written while locked");
  a_reset_outside: assert property (
    active && meas_done && outside ##1 active |-> io_hiz_reset)
    else $error("no reset on out-of-window count");
  a_reset_release: assert property (
    io_hiz_reset && active && !meas_done |=> io_hiz_reset)
    else $error("reset released without in-window count");
  a_stop_suspend: assert property (
    stop_mode |=> !io_hiz_reset)
    else $error("monitor reset during stop");
  a_force_direct: assert property (
    $rose(io_hiz_reset) && $past(multiplier_active)
    && multiplier_active |-> !use_mult)
    else $error("direct pair not forced");
  a_key_reset: assert property (
    $rose(aresetn) |-> key_ff == ofm_pkg::KEY_LOCK && en_ff == 8'h00)
    else $error("reset values wrong");

  c_enable: cover property (wr_ok_en && s_axi_wdata[7:0] == ofm_pkg::EN_ON);
  c_reset: cover property ($rose(io_hiz_reset));
  c_release: cover property ($fell(io_hiz_reset) && active);
  c_stopped: cover property (clock_stop_hold);
endmodule
